// File: bench/dcm_analog_model.sv
// Purpose: analog side of the port pins and the two comparators
// Assumes: voltages are 8-bit codes, index 0..4 pins, 5 reference
// Notes: comparator outputs answer at once; the design registers them
`timescale 1ns/1ps
`default_nettype none
module dcm_analog_model
    import dcm_pkg::*;
(
    input wire logic [47:0] volt,
    input wire dcm_route_type route,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe_n,
    output logic [1:0] comp_raw,
    output logic [4:0] pin_in
);
    // ************************************************************
    // input selection and comparison
    // ************************************************************
    function automatic logic [7:0] pick(input logic [2:0] code);
        if (code == DCM_SEL_VREF) begin
            return volt[47:40];
        end
        if (code <= DCM_SEL_PIN3) begin
            return volt[code*8 +: 8];
        end
        return 8'h00;
    endfunction : pick

    always_comb begin
        comp_raw[0] = route.comp_en[0] && (pick(route.c1_pos) > pick(route.c1_neg));
        comp_raw[1] = route.comp_en[1] && (pick(route.c2_pos) > pick(route.c2_neg));
    end

    // ************************************************************
    // pin levels
    // ************************************************************
    // a driven pin shows the device's level; otherwise the source level
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : volt[i*8+7];
        end
    end
endmodule : dcm_analog_model
`default_nettype wire

// File: bench/test_dual_comparator_mode_control.sv
// Purpose: self-checking bench of the comparator mode control
// Assumes: one register access at a time, Avalon-MM master
// Notes: settle waits cover the one-cycle lags of route and results
`timescale 1ns/1ps
`default_nettype none
module test_dual_comparator_mode_control;
    import dcm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] comp_raw;
    logic [4:0] port_latch = 5'h00;
    logic [4:0] pin_in, pin_out, pin_oe_n, port_read;
    dcm_route_type route;
    logic irq;
    logic [47:0] volt = 48'h80_40_80_c0_40_00;
    int err_count = 0;
    int check_count = 0;
    logic [7:0] rd;

    dcm_mode_control dut (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .comp_raw(comp_raw), .port_latch(port_latch), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .port_read(port_read), .route(route), .irq(irq));
    dcm_analog_model far (.volt(volt), .route(route), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .comp_raw(comp_raw), .pin_in(pin_in));

    initial begin
        forever #5 clk = ~clk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    // request held until waitrequest is seen low at an edge
    // only the watchdog ends a wait that never gets its answer
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, wd};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic sc_reset();
        logic [7:0] idx [5] = '{DCM_IDX_COMP_CTRL, DCM_IDX_PORT_DIR, DCM_IDX_IRQ_STATUS,
            DCM_IDX_IRQ_MASK, DCM_IDX_IRQ_CTRL};
        logic [7:0] exp [5] = '{8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, idx[i], 8'h00);
            chk_val({24'h0, rd}, {24'h0, exp[i]});
        end
        chk_val({27'h0, pin_oe_n}, 32'h1f);
        chk_val({28'h0, route.analog}, 32'hf);
        bus(1'b0, 8'h40, 8'h00);
        chk_val({24'h0, rd}, 32'h0);
    endtask : sc_reset

    task automatic sc_readonly();
        bus(1'b1, DCM_IDX_COMP_CTRL, 8'hff);
        bus(1'b0, DCM_IDX_COMP_CTRL, 8'h00);
        chk_val({24'h0, rd}, 32'h0f);
    endtask : sc_readonly

    task automatic sc_modes();
        logic [1:0] en [8] = '{2'b00, 2'b11, 2'b11, 2'b11, 2'b11, 2'b10, 2'b11, 2'b00};
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, DCM_IDX_COMP_CTRL, m[7:0]);
            settle();
            chk_val({30'h0, route.comp_en}, {30'h0, en[m]});
        end
        bus(1'b1, DCM_IDX_COMP_CTRL, 8'h0a);
        settle();
        chk_val({20'h0, route.c1_neg, route.c1_pos, route.c2_neg, route.c2_pos}, 32'h0714);
        bus(1'b1, DCM_IDX_COMP_CTRL, 8'h01);
        settle();
        chk_val({20'h0, route.c1_neg, route.c1_pos, route.c2_neg, route.c2_pos}, 32'h008a);
    endtask : sc_modes

    task automatic sc_common_ref();
        port_latch <= 5'h18;
        bus(1'b1, DCM_IDX_COMP_CTRL, 8'h03);
        bus(1'b1, DCM_IDX_PORT_DIR, 8'h07);
        repeat (1000) @(posedge clk);
        chk_val({20'h0, route.c1_neg, route.c1_pos, route.c2_neg, route.c2_pos}, 32'h008a);
        chk_val({27'h0, pin_oe_n}, 32'h07);
        chk_val({27'h0, pin_out}, 32'h18);
        chk_val({27'h0, port_read}, 32'h18);
        bus(1'b0, DCM_IDX_COMP_CTRL, 8'h00);
        chk_val({24'h0, rd}, 32'hc3);
    endtask : sc_common_ref

    task automatic sc_irq();
        bus(1'b1, DCM_IDX_IRQ_STATUS, 8'h01);
        bus(1'b1, DCM_IDX_IRQ_MASK, 8'h01);
        bus(1'b1, DCM_IDX_IRQ_CTRL, 8'hc0);
        settle();
        chk_val({31'h0, irq}, 32'h0);
        // pin 0 above pin 2 turns the first comparator low
        volt[7:0] <= 8'he0;
        settle();
        bus(1'b0, DCM_IDX_IRQ_STATUS, 8'h00);
        chk_val({24'h0, rd}, 32'h01);
        chk_val({31'h0, irq}, 32'h1);
        bus(1'b1, DCM_IDX_IRQ_MASK, 8'h00);
        settle();
        chk_val({31'h0, irq}, 32'h0);
        bus(1'b1, DCM_IDX_IRQ_MASK, 8'h01);
        bus(1'b1, DCM_IDX_IRQ_STATUS, 8'h01);
        settle();
        bus(1'b0, DCM_IDX_IRQ_STATUS, 8'h00);
        chk_val({24'h0, rd}, 32'h01);
        bus(1'b0, DCM_IDX_COMP_CTRL, 8'h00);
        chk_val({24'h0, rd}, 32'h83);
        bus(1'b1, DCM_IDX_IRQ_STATUS, 8'h01);
        settle();
        bus(1'b0, DCM_IDX_IRQ_STATUS, 8'h00);
        chk_val({24'h0, rd}, 32'h00);
        chk_val({31'h0, irq}, 32'h0);
    endtask : sc_irq

    task automatic sc_out_pins();
        bus(1'b1, DCM_IDX_IRQ_MASK, 8'h00);
        port_latch <= 5'h00;
        volt[15:0] <= 16'h10_40;
        bus(1'b1, DCM_IDX_COMP_CTRL, 8'h06);
        settle();
        chk_val({30'h0, pin_out[4:3]}, 32'h3);
        volt[7:0] <= 8'he0;
        settle();
        chk_val({30'h0, pin_out[4:3]}, 32'h2);
    endtask : sc_out_pins

    // with the clock enable low a comparator change must not reach the pins
    task automatic sc_ce_freeze();
        ce <= 1'b0;
        volt[7:0] <= 8'h00;
        settle();
        chk_val({30'h0, pin_out[4:3]}, 32'h2);
        ce <= 1'b1;
        settle();
        chk_val({30'h0, pin_out[4:3]}, 32'h3);
    endtask : sc_ce_freeze

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        sc_reset();
        sc_readonly();
        sc_modes();
        sc_common_ref();
        sc_irq();
        sc_out_pins();
        sc_ce_freeze();
        conclude();
    end

    // watchdog: the full run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule : test_dual_comparator_mode_control
`default_nettype wire

// File: src/dcm_mode_control.sv
// Purpose: digital control of a two-comparator analog module
// Assumes: comparator results and pin levels are synchronous to clk
// Notes: register slave on Avalon-MM with waitrequest
// Behaviour
// - two comparator channels, each result a separate bit.
// - comparator inputs share port A pins 0 to 3 with port logic.
// - voltage reference selectable as comparator input in modes needing it.
// - control register drives input and output multiplexer selects.
// - three-bit mode field selects one of eight pin routings.
// - control register at 1Fh; results bits 7,6; switch bit 3; mode 2:0.
// - unimplemented bits, including control bits 5 and 4, read zero.
// - direction register keeps controlling pin direction in every mode.
// - mode 011 routes pins 0,1 to inverting, pin 2 non-inverting.
// - mode 011 leaves pins 3 and 4 digital under direction control.
// - result bits are read-only; writes to them do nothing.
// - change flag set while either result differs from latched value.
// - any control register access latches results, ending the mismatch.
// - reset puts mode 000, all comparator pins analog.
`timescale 1ns/1ps
`default_nettype none
module dcm_mode_control
    import dcm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [DCM_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [1:0] comp_raw,
    input wire logic [4:0] port_latch,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe_n,
    output logic [4:0] port_read,
    output dcm_route_type route,
    output logic irq
);

    // ************************************************************
    // bus slave
    // ************************************************************
    logic wait_r;
    logic [31:0] rdata_r;
    logic req;
    logic take;
    logic take_wr;
    logic [7:0] idx;
    logic word_ok;
    logic sel_ctl;
    logic sel_dir;
    logic sel_sts;
    logic sel_msk;
    logic sel_gct;
    logic [31:0] rdata_nxt;

    // state registers
    logic [3:0] ctl_r;
    logic [4:0] dir_r;
    logic [1:0] result_r;
    logic [1:0] last_r;
    logic flag_r;
    logic mask_r;
    logic [1:0] gctl_r;
    logic irq_r;
    dcm_route_type route_r;
    logic [4:0] pin_out_r;
    logic [4:0] oe_n_r;
    logic [4:0] port_read_r;
    logic mismatch;

    assign req = avs_read | avs_write;
    assign take = ce & req & ~wait_r;
    assign take_wr = take & avs_write & avs_byteenable[0];
    assign idx = avs_address[9:2];
    assign word_ok = (avs_address[1:0] == 2'h0);
    assign sel_ctl = word_ok & (idx == DCM_IDX_COMP_CTRL);
    assign sel_dir = word_ok & (idx == DCM_IDX_PORT_DIR);
    assign sel_sts = word_ok & (idx == DCM_IDX_IRQ_STATUS);
    assign sel_msk = word_ok & (idx == DCM_IDX_IRQ_MASK);
    assign sel_gct = word_ok & (idx == DCM_IDX_IRQ_CTRL);
    assign mismatch = (result_r != last_r);

    // one wait cycle, then a single-cycle acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else if (ce) begin
            wait_r <= ~(req & wait_r);
        end
    end

    always_comb begin
        rdata_nxt = DCM_UNMAPPED_READ;
        if (sel_ctl) begin
            // bits 5 and 4 are unimplemented and read zero
            rdata_nxt[DCM_POS_SECOND_RESULT] = result_r[1];
            rdata_nxt[DCM_POS_FIRST_RESULT] = result_r[0];
            rdata_nxt[DCM_POS_INPUT_SWITCH] = ctl_r[3];
            rdata_nxt[DCM_POS_MODE_LSB +: 3] = ctl_r[2:0];
        end else if (sel_dir) begin
            rdata_nxt[4:0] = dir_r;
        end else if (sel_sts) begin
            rdata_nxt[DCM_POS_CHANGE_FLAG] = flag_r;
        end else if (sel_msk) begin
            rdata_nxt[DCM_POS_CHANGE_FLAG] = mask_r;
        end else if (sel_gct) begin
            rdata_nxt[DCM_POS_GLOBAL_IRQ] = gctl_r[1];
            rdata_nxt[DCM_POS_PERIPH_IRQ] = gctl_r[0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= DCM_UNMAPPED_READ;
        end else if (ce && avs_read && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ************************************************************
    // control and direction registers
    // ************************************************************
    // result bits are not stored here, so writes to them fall away
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= DCM_RST_COMP_CTRL;
        end else if (take_wr && sel_ctl) begin
            ctl_r <= {avs_writedata[DCM_POS_INPUT_SWITCH], avs_writedata[DCM_POS_MODE_LSB +: 3]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= DCM_RST_PORT_DIR;
        end else if (take_wr && sel_dir) begin
            dir_r <= avs_writedata[4:0];
        end
    end

    // ************************************************************
    // routing
    // ************************************************************
    function automatic dcm_route_type route_of(input logic [2:0] mode, input logic sw);
        dcm_route_type r;
        r = DCM_ROUTE_IDLE;
        unique case (dcm_mode_type'(mode))
            DCM_MODE_RESET: begin
                r.analog = 4'hf;
            end
            DCM_MODE_THREE_IN: begin
                r.c1_neg = sw ? DCM_SEL_PIN3 : DCM_SEL_PIN0;
                r.c1_pos = DCM_SEL_PIN2;
                r.c2_neg = DCM_SEL_PIN1;
                r.c2_pos = DCM_SEL_PIN2;
                r.comp_en = 2'h3;
                r.analog = 4'hf;
            end
            DCM_MODE_FOUR_VREF: begin
                r.c1_neg = sw ? DCM_SEL_PIN3 : DCM_SEL_PIN0;
                r.c2_neg = sw ? DCM_SEL_PIN2 : DCM_SEL_PIN1;
                r.c1_pos = DCM_SEL_VREF;
                r.c2_pos = DCM_SEL_VREF;
                r.comp_en = 2'h3;
                r.analog = 4'hf;
            end
            DCM_MODE_COMMON_REF, DCM_MODE_COMMON_OUT: begin
                r.c1_neg = DCM_SEL_PIN0;
                r.c2_neg = DCM_SEL_PIN1;
                r.c1_pos = DCM_SEL_PIN2;
                r.c2_pos = DCM_SEL_PIN2;
                r.comp_en = 2'h3;
                r.analog = 4'h7;
                r.out_mux = (mode == DCM_MODE_COMMON_OUT);
            end
            DCM_MODE_TWO_INDEP: begin
                r.c1_neg = DCM_SEL_PIN0;
                r.c1_pos = DCM_SEL_PIN3;
                r.c2_neg = DCM_SEL_PIN1;
                r.c2_pos = DCM_SEL_PIN2;
                r.comp_en = 2'h3;
                r.analog = 4'hf;
            end
            DCM_MODE_ONE_INDEP: begin
                r.c2_neg = DCM_SEL_PIN1;
                r.c2_pos = DCM_SEL_PIN2;
                r.comp_en = 2'h2;
                r.analog = 4'h6;
            end
            DCM_MODE_OFF: begin
                r = DCM_ROUTE_IDLE;
            end
        endcase
        return r;
    endfunction : route_of

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // literal reset value: a function call is not a constant in an async branch
            route_r <= '{DCM_SEL_NONE, DCM_SEL_NONE, DCM_SEL_NONE, DCM_SEL_NONE, 2'h0, 4'hf, 1'b0};
        end else if (ce) begin
            route_r <= route_of(ctl_r[2:0], ctl_r[3]);
        end
    end

    // ************************************************************
    // comparator results and change detection
    // ************************************************************
    // a powered-down comparator reads low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= 2'h0;
        end else if (ce) begin
            result_r <= comp_raw & route_r.comp_en;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 2'h0;
        end else if (take && sel_ctl) begin
            last_r <= result_r;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (ce) begin
            if (mismatch) begin
                flag_r <= 1'b1;
            end else if (take_wr && sel_sts && avs_writedata[DCM_POS_CHANGE_FLAG]) begin
                flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= 1'b0;
            gctl_r <= 2'h0;
        end else if (take_wr) begin
            if (sel_msk) begin
                mask_r <= avs_writedata[DCM_POS_CHANGE_FLAG];
            end
            if (sel_gct) begin
                gctl_r <= {avs_writedata[DCM_POS_GLOBAL_IRQ], avs_writedata[DCM_POS_PERIPH_IRQ]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= flag_r & mask_r & gctl_r[0] & gctl_r[1];
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    // comparator outputs reach the pins two cycles late, via the result register, not unsynchronised
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_r <= 5'h00;
            oe_n_r <= DCM_RST_PORT_DIR;
            port_read_r <= 5'h00;
        end else if (ce) begin
            pin_out_r <= route_r.out_mux ? {result_r, port_latch[2:0]} : port_latch;
            oe_n_r <= dir_r;
            port_read_r <= pin_in & ~{1'b0, route_r.analog};
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign pin_out = pin_out_r;
    assign pin_oe_n = oe_n_r;
    assign port_read = port_read_r;
    assign route = route_r;
    assign irq = irq_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_req_wait;
        ce && req && wait_r;
    endsequence

    sequence seq_ack;
        !avs_waitrequest;
    endsequence

    AST_BUS_ACK: assert property (seq_req_wait ##1 ce |-> seq_ack)
        else $error("no acknowledge one cycle after request");
    AST_MODE_WRITE: assert property (take_wr && sel_ctl |=> ctl_r[2:0] == $past(avs_writedata[2:0]))
        else $error("mode field did not take written value");
    AST_RESULT_RO: assert property (take_wr && sel_ctl && ce |=> result_r == ($past(comp_raw) & $past(route_r.comp_en)))
        else $error("result bits affected by write");
    AST_UNIMPL_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0
        && (!(avs_read && sel_ctl) || avs_readdata[5:4] == 2'h0))
        else $error("unimplemented bits read nonzero");
    AST_FLAG_SET: assert property (ce && mismatch |=> flag_r)
        else $error("change flag not set on mismatch");
    AST_LATCH: assert property (take && sel_ctl |=> last_r == $past(result_r))
        else $error("access did not latch results");
    AST_DIR_OE: assert property (ce ##1 ce |-> pin_oe_n == $past(dir_r))
        else $error("pin direction not following direction register");
    AST_COMMON_REF: assert property (ce && ctl_r[2:0] == DCM_MODE_COMMON_REF |=> route_r.c1_neg == DCM_SEL_PIN0
        && route_r.c2_neg == DCM_SEL_PIN1 && route_r.c1_pos == DCM_SEL_PIN2 && route_r.c2_pos == DCM_SEL_PIN2)
        else $error("common reference routing wrong");
    AST_DIGITAL_PINS: assert property (ce && route_r.analog == 4'h7 && !route_r.out_mux
        |=> pin_out[4:3] == $past(port_latch[4:3]))
        else $error("pins 3 and 4 not digital in common reference mode");
    AST_OUT_MUX: assert property (ce && route_r.out_mux |=> pin_out[4:3] == $past(result_r))
        else $error("comparator outputs not on pins");
    AST_VREF: assert property (ce && ctl_r[2:0] == DCM_MODE_FOUR_VREF |=> route_r.c1_pos == DCM_SEL_VREF)
        else $error("reference not selected");
    AST_SWITCH: assert property (ce && ctl_r[3] &&
        (ctl_r[2:0] == DCM_MODE_THREE_IN || ctl_r[2:0] == DCM_MODE_FOUR_VREF) |=> route_r.c1_neg == DCM_SEL_PIN3)
        else $error("input switch not honoured");
    AST_RESULT_OFF: assert property (ce && !route_r.comp_en[0] |=> !result_r[0])
        else $error("disabled comparator reads high");
    AST_RESET_MODE: assert property ($rose(rst_n) |-> ctl_r[2:0] == DCM_MODE_RESET && route_r.analog == 4'hf)
        else $error("reset mode not applied");
    AST_CE_FREEZE: assert property (!ce |=> $stable(ctl_r) && $stable(flag_r) && $stable(result_r)
        && $stable(pin_out) && $stable(avs_waitrequest))
        else $error("state changed while clock enable low");

endmodule : dcm_mode_control
`default_nettype wire

// File: src/dcm_pkg.sv
// Purpose: shared constants and types of the dual comparator mode control
// Assumes: Avalon-MM slave with 32-bit data, one register per aligned word
// Notes: register indices are kept; byte address is four times the index
package dcm_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int DCM_ADDR_W = 10;
    localparam logic [7:0] DCM_IDX_COMP_CTRL = 8'h1f;
    localparam logic [7:0] DCM_IDX_PORT_DIR = 8'h85;
    localparam logic [7:0] DCM_IDX_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] DCM_IDX_IRQ_MASK = 8'h8c;
    localparam logic [7:0] DCM_IDX_IRQ_CTRL = 8'h0b;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DCM_POS_SECOND_RESULT = 7;
    localparam int DCM_POS_FIRST_RESULT = 6;
    localparam int DCM_POS_INPUT_SWITCH = 3;
    localparam int DCM_POS_MODE_LSB = 0;
    localparam int DCM_POS_CHANGE_FLAG = 0;
    localparam int DCM_POS_GLOBAL_IRQ = 7;
    localparam int DCM_POS_PERIPH_IRQ = 6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] DCM_RST_COMP_CTRL = 4'h0;
    localparam logic [4:0] DCM_RST_PORT_DIR = 5'h1f;
    localparam logic [31:0] DCM_UNMAPPED_READ = 32'h0000_0000;

    // ************************************************************
    // modes and routing
    // ************************************************************
    typedef enum logic [2:0] {
        DCM_MODE_RESET = 3'b000,
        DCM_MODE_THREE_IN = 3'b001,
        DCM_MODE_FOUR_VREF = 3'b010,
        DCM_MODE_COMMON_REF = 3'b011,
        DCM_MODE_TWO_INDEP = 3'b100,
        DCM_MODE_ONE_INDEP = 3'b101,
        DCM_MODE_COMMON_OUT = 3'b110,
        DCM_MODE_OFF = 3'b111
    } dcm_mode_type;

    // input selector codes: a port A pin, the voltage reference, or nothing
    localparam logic [2:0] DCM_SEL_PIN0 = 3'h0;
    localparam logic [2:0] DCM_SEL_PIN1 = 3'h1;
    localparam logic [2:0] DCM_SEL_PIN2 = 3'h2;
    localparam logic [2:0] DCM_SEL_PIN3 = 3'h3;
    localparam logic [2:0] DCM_SEL_VREF = 3'h4;
    localparam logic [2:0] DCM_SEL_NONE = 3'h7;

    typedef struct packed {
        logic [2:0] c1_neg;
        logic [2:0] c1_pos;
        logic [2:0] c2_neg;
        logic [2:0] c2_pos;
        logic [1:0] comp_en;
        logic [3:0] analog;
        logic out_mux;
    } dcm_route_type;

    localparam dcm_route_type DCM_ROUTE_IDLE = '{DCM_SEL_NONE, DCM_SEL_NONE,
        DCM_SEL_NONE, DCM_SEL_NONE, 2'h0, 4'h0, 1'b0};

endpackage : dcm_pkg
